// ==== hdl/csl_pkg.sv ====
/*
  Package for the clock stop and strap latch block: counts, reset values,
  state encodings and the divider figures for the emulated clock groups.
  Assumes a single 10 MHz system clock; all output clocks are divided from it.
*/
package csl_pkg;

  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  // Power-up timer, longest time, rounded down to whole cycles
  localparam int unsigned PWRUP_TIME_MS   = 3;
  localparam int unsigned PWRUP_CYCLES    = (CLK_HZ / 1000) * PWRUP_TIME_MS;
  localparam int unsigned PWRUP_W         = 15;

  localparam int unsigned N_STRAP         = 5;
  localparam int unsigned N_CPU           = 4;
  localparam int unsigned N_PCI           = 5;

  // Half periods in system cycles of the emulated clock groups
  localparam int unsigned CPU_HALF        = 1;
  localparam int unsigned PCI_HALF        = 2;
  localparam int unsigned OTH_HALF        = 4;
  localparam int unsigned DIV_W           = 4;

  localparam logic [N_STRAP-1:0] STRAP_RST = 5'h00;

  typedef enum logic [2:0] {
    CSL_ST_SAMPLE = 3'h1,
    CSL_ST_HOLD   = 3'h2,
    CSL_ST_RUN    = 3'h4
  } csl_phase_t;

endpackage : csl_pkg

// ==== hdl/csl_gate.sv ====
/*
  One clock group: a divider producing a square wave and a stop gate that
  changes only while the wave is low, so the gated output never shows a runt.
  Assumes stop_n arrives synchronous to clk.
*/
`timescale 1ns/1ps
module csl_gate #(
  parameter int unsigned HALF = 1,
  parameter int unsigned W    = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         run,
  input  wire logic         stop_n,
  output logic              free_clk,
  output logic [W-1:0]      gated_clk
);
  import csl_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             wave;
    logic             stop;
    logic [W-1:0]     out;
  } csl_gate_st_t;

  csl_gate_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (run) begin
      if (s_q.cnt == DIV_W'(HALF - 1)) begin
        s_d.cnt  = '0;
        s_d.wave = ~s_q.wave;
      end else begin
        s_d.cnt = s_q.cnt + DIV_W'(1);
      end
    end
    // Gate moves only on the edge where the wave goes low or stays low
    if (!s_d.wave)
      s_d.stop = ~stop_n;
    s_d.out = (s_d.wave && !s_d.stop) ? '1 : '0;
  end

  always_ff @(posedge clk) begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign free_clk  = s_q.wave;
  assign gated_clk = s_q.out;

endmodule : csl_gate

// ==== hdl/csl_top.sv ====
/*
  Clock stop and strap latch top: latches five straps at reset release,
  holds the dual-function pins low until the power-up timer ends, then runs
  the CPU, gated PCI, free PCI and other clock groups, with stop gating on the CPU and gated PCI groups only.
  Assumes stop inputs change on rising edges of the free PCI clock and that
  rst models power-on reset.
*/
`timescale 1ns/1ps
module csl_top #(
  parameter int unsigned PWRUP_CNT = csl_pkg::PWRUP_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        cpu_stop_n,
  input  wire logic                        pci_stop_n,
  input  wire logic [csl_pkg::N_STRAP-1:0] strap_in,
  input  wire logic [csl_pkg::N_STRAP-1:0] strap_driven,
  output logic      [csl_pkg::N_STRAP-1:0] strap_out,
  output logic      [csl_pkg::N_STRAP-1:0] strap_oe,
  output logic      [csl_pkg::N_STRAP-1:0] strap_cfg,
  output logic      [csl_pkg::N_CPU-1:0]   cpu_clk,
  output logic      [csl_pkg::N_PCI-1:0]   gated_pci_clock,
  output logic                             free_running_pci_clock,
  output logic                             other_clk
);
  import csl_pkg::*;

  typedef struct packed {
    csl_phase_t            phase;
    logic [PWRUP_W-1:0]    tmr;
    logic [N_STRAP-1:0]    cfg;
    logic [N_STRAP-1:0]    oe;
    logic [N_STRAP-1:0]    pin;
    logic                  run;
  } csl_top_st_t;

  csl_top_st_t s_q, s_d;

  logic                  pci_free_w;
  logic [N_PCI-1:0]      pci_gated_w;
  logic                  cpu_free_w;
  logic [N_CPU-1:0]      cpu_gated_w;
  logic                  oth_free_w;
  logic                  oth_unused_w;
  logic [N_CPU-1:0]      cpu_q;
  logic [N_PCI-1:0]      pci_q;
  logic                  pcif_q;
  logic                  oth_q;

  always_comb begin
    s_d = s_q;
    case (s_q.phase)
      CSL_ST_SAMPLE: begin
        // Undriven pins see the pull-up and read as one
        s_d.cfg   = (strap_in & strap_driven) | ~strap_driven;
        s_d.oe    = '1;
        s_d.pin   = '0;
        s_d.phase = CSL_ST_HOLD;
      end
      CSL_ST_HOLD: begin
        if (s_q.tmr == PWRUP_W'(PWRUP_CNT - 1)) begin
          s_d.run   = 1'b1;
          s_d.phase = CSL_ST_RUN;
        end else begin
          s_d.tmr = s_q.tmr + PWRUP_W'(1);
        end
      end
      CSL_ST_RUN: begin
        // Configuration no longer follows the pins
        s_d.pin = {N_STRAP{oth_free_w}};
      end
      default: begin
        s_d.phase = CSL_ST_SAMPLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.phase <= CSL_ST_SAMPLE;
      s_q.tmr   <= '0;
      s_q.cfg   <= STRAP_RST;
      s_q.oe    <= '0;
      s_q.pin   <= '0;
      s_q.run   <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Free PCI group also carries the gated PCI outputs
  csl_gate #(
    .HALF (PCI_HALF),
    .W    (N_PCI)
  ) u_pci (
    .clk       (clk),
    .rst       (rst),
    .run       (s_q.run),
    .stop_n    (pci_stop_n),
    .free_clk  (pci_free_w),
    .gated_clk (pci_gated_w)
  );

  // Fastest group: half period of one cycle keeps the latency under two periods
  csl_gate #(
    .HALF (CPU_HALF),
    .W    (N_CPU)
  ) u_cpu (
    .clk       (clk),
    .rst       (rst),
    .run       (s_q.run),
    .stop_n    (cpu_stop_n),
    .free_clk  (cpu_free_w),
    .gated_clk (cpu_gated_w)
  );

  // Never stopped, stands for every ungated clock
  csl_gate #(
    .HALF (OTH_HALF),
    .W    (1)
  ) u_oth (
    .clk       (clk),
    .rst       (rst),
    .run       (s_q.run),
    .stop_n    (1'b1),
    .free_clk  (oth_free_w),
    .gated_clk (oth_unused_w)
  );

  // Retiming gives every clock output straight from a flip-flop at one cycle cost
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_q  <= '0;
      pci_q  <= '0;
      pcif_q <= 1'b0;
      oth_q  <= 1'b0;
    end else begin
      cpu_q  <= cpu_gated_w;
      pci_q  <= pci_gated_w;
      pcif_q <= pci_free_w;
      oth_q  <= oth_unused_w;
    end
  end

  assign cpu_clk                = cpu_q;
  assign gated_pci_clock        = pci_q;
  assign free_running_pci_clock = pcif_q;
  assign other_clk              = oth_q;
  assign strap_out              = s_q.pin;
  assign strap_oe               = s_q.oe;
  assign strap_cfg              = s_q.cfg;

endmodule : csl_top

// ==== verification/csl_ctl_model.sv ====
/*
  Chipset stop controller model: moves both stop inputs only where the free
  PCI clock has risen. Assumes the wanted stop levels come from the bench.
*/
`timescale 1ns/1ps
module csl_ctl_model (
  input  wire logic clk,
  input  wire logic free_clk,
  input  wire logic cpu_want_n,
  input  wire logic pci_want_n,
  output logic      cpu_stop_n,
  output logic      pci_stop_n
);
  logic free_q = 1'b0;
  initial begin
    cpu_stop_n = 1'b1;
    pci_stop_n = 1'b1;
  end
  // Edge seen one cycle late, so stops move just after the free clock rises
  always @(posedge clk) begin
    free_q <= free_clk;
    if (free_clk && !free_q) begin
      cpu_stop_n <= cpu_want_n;
      pci_stop_n <= pci_want_n;
    end
  end
endmodule : csl_ctl_model

// ==== verification/csl_chk.sv ====
/*
  Checker for csl_top ports: stop latency, pulse widths, strap capture and
  power-up quiet time. Assumes one clock and synchronous active-high rst.
*/
`timescale 1ns/1ps
module csl_chk import csl_pkg::*; #(
  parameter int unsigned PWRUP_CNT = 20
) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               cpu_stop_n,
  input wire logic               pci_stop_n,
  input wire logic [N_STRAP-1:0] strap_in,
  input wire logic [N_STRAP-1:0] strap_driven,
  input wire logic [N_STRAP-1:0] strap_out,
  input wire logic [N_STRAP-1:0] strap_oe,
  input wire logic [N_STRAP-1:0] strap_cfg,
  input wire logic [N_CPU-1:0]   cpu_clk,
  input wire logic [N_PCI-1:0]   gated_pci_clock,
  input wire logic               free_running_pci_clock,
  input wire logic               other_clk
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] cnt_q;
  always_ff @(posedge clk) begin
    cnt_q <= rst ? 16'h0000 : cnt_q + 16'(cnt_q != 16'hffff);
  end
  AST_CPU_STOP: assert property (!cpu_stop_n [*4] |-> cpu_clk == 4'h0)
    else $error("cpu clocks not parked");
  AST_PCI_STOP: assert property (!pci_stop_n [*5] |-> gated_pci_clock == 5'h00)
    else $error("pci clocks not parked");
  AST_PCI_PULSE: assert property ($rose(gated_pci_clock[0]) |=> gated_pci_clock[0] ##1
    !gated_pci_clock[0]) else $error("pci runt pulse");
  AST_FREE_RUN: assert property ($rose(free_running_pci_clock) |-> ##4
    $rose(free_running_pci_clock)) else $error("free clock stalled");
  AST_OTHER_RUN: assert property ($rose(other_clk) |-> ##8 $rose(other_clk))
    else $error("other clock stalled");
  AST_STRAP_CFG: assert property ($fell(rst) |=> strap_cfg == (($past(strap_in) &
    $past(strap_driven)) | ~$past(strap_driven))) else $error("strap capture wrong");
  AST_STRAP_OE: assert property (!$past(rst) |-> strap_oe == 5'h1f)
    else $error("strap pins not driven");
  AST_STRAP_HOLD: assert property (!$fell(rst) |=> $stable(strap_cfg))
    else $error("strap config moved");
  AST_PWRUP_QUIET: assert property (cnt_q <= PWRUP_CNT |-> {strap_out, cpu_clk} == 9'h000)
    else $error("outputs toggled early");
  AST_PWRUP_START: assert property (cnt_q == PWRUP_CNT |-> ##[1:8] $rose(other_clk))
    else $error("outputs late");
endmodule : csl_chk
bind csl_top csl_chk #(.PWRUP_CNT(PWRUP_CNT)) u_chk (.clk(clk), .rst(rst),
  .cpu_stop_n(cpu_stop_n), .pci_stop_n(pci_stop_n), .strap_in(strap_in),
  .strap_driven(strap_driven), .strap_out(strap_out), .strap_oe(strap_oe),
  .strap_cfg(strap_cfg), .cpu_clk(cpu_clk), .gated_pci_clock(gated_pci_clock),
  .free_running_pci_clock(free_running_pci_clock), .other_clk(other_clk));

// ==== verification/test_clock_stop_and_strap_latch.sv ====
/*
  Bench for csl_top: straps and stop patterns, fixed and random.
  Assumes a 10 MHz clock and a shortened power-up count.
*/
`timescale 1ns/1ps
module test_clock_stop_and_strap_latch;
  import csl_pkg::*;
  localparam int unsigned PW = 20;
  logic               clk = 1'b0, rst = 1'b1, cw = 1'b1, pw = 1'b1;
  logic [N_STRAP-1:0] s_in = 5'h00, s_drv = 5'h00, cfg_e, s_out, s_oe, s_cfg, g_pci, h_pci;
  logic [N_CPU-1:0]   cpu, h_cpu;
  logic               free, oth, h_free, h_oth, h_so, c_stop_n, p_stop_n;
  int                 fails = 0, comparisons = 0, cyc = 0;
  csl_top #(.PWRUP_CNT(PW)) DUT (.clk(clk), .rst(rst), .cpu_stop_n(c_stop_n),
    .pci_stop_n(p_stop_n), .strap_in(s_in), .strap_driven(s_drv), .strap_out(s_out),
    .strap_oe(s_oe), .strap_cfg(s_cfg), .cpu_clk(cpu), .gated_pci_clock(g_pci),
    .free_running_pci_clock(free), .other_clk(oth));
  csl_ctl_model CTL (.clk(clk), .free_clk(free), .cpu_want_n(cw), .pci_want_n(pw),
    .cpu_stop_n(c_stop_n), .pci_stop_n(p_stop_n));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic check5(input logic [4:0] got, input logic [4:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check5
  task automatic final_report;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  task automatic power_up(input logic [4:0] si, input logic [4:0] sd);
    rst <= 1'b1;
    s_in <= si;
    s_drv <= sd;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cfg_e = (si & sd) | ~sd;
    repeat (3) @(posedge clk);
    #1;
    check5(s_cfg, cfg_e);
    check5(s_oe, 5'h1f);
    check5(s_out, 5'h00);
    s_in <= ~si;
    s_drv <= 5'h1f;
    repeat (PW + 8) @(posedge clk);
    #1;
    check5(s_cfg, cfg_e);
  endtask : power_up
  // Stop wants are active low; window covers model delay plus stop latency
  task automatic run_stops(input logic c, input logic p);
    cw <= c;
    pw <= p;
    repeat (12) @(posedge clk);
    {h_cpu, h_pci, h_free, h_oth, h_so} = '0;
    repeat (8) begin
      @(posedge clk);
      #1;
      {h_cpu, h_pci} = {h_cpu | cpu, h_pci | g_pci};
      {h_free, h_oth, h_so} = {h_free | free, h_oth | oth, h_so | (|s_out)};
    end
    check5({h_cpu, h_free}, {{4{c}}, 1'b1});
    check5(h_pci, {5{p}});
    check5({3'h0, h_oth, h_so}, 5'h03);
  endtask : run_stops
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    void'($urandom(32'h0c89c0e8));
    power_up(5'h00, 5'h00);
    for (int i = 0; i < 4; i++) run_stops(i[0], i[1]);
    power_up(5'($urandom), 5'($urandom));
    repeat (6) run_stops(1'($urandom), 1'($urandom));
    final_report();
  end
endmodule : test_clock_stop_and_strap_latch
